// *** bench/bmrx_exec_asserts.sv ***
/* concurrent checks on the ports of bmrx_exec.
   assumes one clock, async active-low reset, ops taken when not busy. */
module bmrx_exec_asserts (
	// watched ports
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire bmrx_pkg::bmrx_instr_t instr,
	input wire logic busy,
	input wire logic [7:0] file_rd_data,
	input wire bmrx_pkg::bmrx_fwr_t file_wr,
	input wire logic [12:0] stack_top,
	input wire logic stack_pop,
	input wire logic [7:0] accum,
	input wire logic zero_flag,
	input wire logic [12:0] pc,
	input wire logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	import bmrx_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire tk = instr_valid && !busy;
	a_ret_pop: assert property (tk && instr.op inside
		{BMRX_OP_RETURN, BMRX_OP_RETURN_LITERAL} |=> stack_pop && busy &&
		pc == $past(stack_top)) else $error("return did not pop");
	a_ret_done: assert property (stack_pop |=> done && !busy)
		else $error("return not two cycles");
	a_one_cyc: assert property (tk && instr.op inside
		{[BMRX_OP_INCREMENT_FILE:BMRX_OP_STORE_ACCUM]} |=> done && !busy)
		else $error("op not single cycle");
	a_flag_kept: assert property (tk && instr.op inside
		{[BMRX_OP_LOAD_LITERAL:BMRX_OP_RETURN]} |=> $stable(zero_flag))
		else $error("zero flag changed");
	a_zero_acc: assert property (tk && !instr.dest_file &&
		instr.op inside {[BMRX_OP_INCREMENT_FILE:BMRX_OP_COPY_FILE]} |=>
		zero_flag == (accum == 8'h00)) else $error("zero flag wrong");
	a_lit_load: assert property (tk && instr.op inside
		{BMRX_OP_LOAD_LITERAL, BMRX_OP_RETURN_LITERAL} |=>
		accum == $past(instr.literal)) else $error("literal not loaded");
	a_store_wr: assert property (tk && instr.op == BMRX_OP_STORE_ACCUM
		|=> file_wr.we && file_wr.data == $past(accum))
		else $error("store wrote wrong data");
	a_inc_file: assert property (tk && instr.dest_file &&
		instr.op == BMRX_OP_INCREMENT_FILE |=> file_wr.we &&
		file_wr.data == $past(file_rd_data) + 8'h01) else $error("bad inc");
	a_file_dest: assert property (tk && instr.dest_file &&
		instr.op inside {[BMRX_OP_INCREMENT_FILE:BMRX_OP_COPY_FILE]} |=>
		file_wr.we && file_wr.addr == $past(instr.file_addr) &&
		accum == $past(accum)) else $error("file target missed");
	a_acc_dest: assert property (tk && !instr.dest_file &&
		instr.op inside {[BMRX_OP_INCREMENT_FILE:BMRX_OP_COPY_FILE]} |=>
		!file_wr.we) else $error("accumulator target wrote file");
	a_copy_zero: assert property (tk &&
		instr.op == BMRX_OP_COPY_FILE |=>
		zero_flag == ($past(file_rd_data) == 8'h00))
		else $error("copy zero flag wrong");
endmodule

bind bmrx_exec bmrx_exec_asserts u_chk (.clk_sys, .rst_n, .instr_valid,
	.instr, .busy, .file_rd_data, .file_wr, .stack_top, .stack_pop,
	.accum, .zero_flag, .pc, .done);

// *** bench/testbench.sv ***
/* self-checking bench for bmrx_exec.
   assumes the file read port and stack are modelled by driven inputs. */
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bmrx_pkg::*;
	logic clk_sys = 0, rst_n = 0, instr_valid = 0;
	bmrx_instr_t instr = '0;
	logic [7:0] file_rd_data = 8'h00, accum;
	logic [6:0] file_rd_addr;
	logic [12:0] stack_top = 13'h0000, pc;
	bmrx_fwr_t file_wr;
	logic busy, stack_pop, zero_flag, done;
	int fails = 0, n_tests = 0, cyc = 0;
	bmrx_exec dut_u (.clk_sys, .rst_n, .instr_valid, .instr, .busy,
		.file_rd_addr, .file_rd_data, .file_wr, .stack_top, .stack_pop,
		.accum, .zero_flag, .pc, .done);
	always #25 clk_sys = ~clk_sys;
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin fails++; wrap_up; end
	end
	task automatic go(bmrx_op_t o, logic [6:0] a, logic d, logic [7:0] l, r);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= '{o, a, d, l};
		file_rd_data <= r;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic t_inc;
		go(BMRX_OP_INCREMENT_FILE, 7'h7f, 1'b0, 8'h00, 8'hff);
		`CHK({accum, zero_flag}, {8'h00, 1'b1})
		`CHK({pc, done}, {13'h0001, 1'b1})
		`CHK(file_wr.we, 1'b0)
		`CHK(file_rd_addr, 7'h7f)
		go(BMRX_OP_INCREMENT_FILE, 7'h7f, 1'b1, 8'h00, 8'h41);
		`CHK(file_wr, {1'b1, 7'h7f, 8'h42})
		`CHK({accum, zero_flag}, {8'h00, 1'b0})
	endtask
	task automatic t_or;
		go(BMRX_OP_LOAD_LITERAL, 7'h00, 1'b0, 8'h00, 8'h00);
		`CHK({accum, zero_flag}, {8'h00, 1'b0})
		go(BMRX_OP_LOAD_LITERAL, 7'h00, 1'b0, 8'h0f, 8'h00);
		`CHK({accum, zero_flag}, {8'h0f, 1'b0})
		go(BMRX_OP_OR_ACCUM_FILE, 7'h00, 1'b0, 8'h00, 8'hf0);
		`CHK({accum, zero_flag}, {8'hff, 1'b0})
		go(BMRX_OP_OR_ACCUM_FILE, 7'h33, 1'b1, 8'h00, 8'h00);
		`CHK({file_wr, accum}, {1'b1, 7'h33, 8'hff, 8'hff})
	endtask
	task automatic t_copy_store;
		go(BMRX_OP_COPY_FILE, 7'h12, 1'b1, 8'h00, 8'h00);
		`CHK({file_wr, zero_flag}, {1'b1, 7'h12, 8'h00, 1'b1})
		go(BMRX_OP_STORE_ACCUM, 7'h00, 1'b0, 8'h00, 8'h00);
		`CHK({file_wr, zero_flag}, {1'b1, 7'h00, 8'hff, 1'b1})
		go(BMRX_OP_COPY_FILE, 7'h12, 1'b0, 8'h00, 8'h80);
		`CHK({accum, zero_flag, file_wr.we}, {8'h80, 2'b00})
		go(BMRX_OP_COPY_FILE, 7'h12, 1'b0, 8'h00, 8'h00);
		`CHK({accum, zero_flag}, {8'h00, 1'b1})
	endtask
	task automatic t_ret(bmrx_op_t o, logic [7:0] lit, logic [7:0] acc,
		logic [12:0] s);
		@(posedge clk_sys);
		stack_top <= s;
		instr_valid <= 1'b1;
		instr <= '{o, 7'h00, 1'b0, lit};
		@(posedge clk_sys);
		// a load left on the bus while busy must be dropped
		instr <= '{BMRX_OP_LOAD_LITERAL, 7'h00, 1'b0, 8'h77};
		#1;
		`CHK({pc, stack_pop, busy, accum}, {s, 2'b11, acc})
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		`CHK({done, busy, stack_pop, zero_flag}, 4'b1001)
		`CHK({pc, accum}, {s, acc})
	endtask
	task automatic t_reset;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		#1;
		`CHK({accum, zero_flag, pc}, 22'h0)
		`CHK({busy, stack_pop, done, file_wr}, 19'h0)
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		go(BMRX_OP_LOAD_LITERAL, 7'h00, 1'b0, 8'h5a, 8'h00);
		`CHK({accum, pc, done}, {8'h5a, 13'h0001, 1'b1})
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_inc;
		t_or;
		t_copy_store;
		t_ret(BMRX_OP_RETURN_LITERAL, 8'ha5, 8'ha5, 13'h1abc);
		t_ret(BMRX_OP_RETURN, 8'h3c, 8'ha5, 13'h0123);
		t_reset;
		wrap_up;
	end
endmodule

// *** hw/bmrx_defs.svh ***
/*
 * constants for the byte move / return execution unit: field widths,
 * reset values and cycle counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef BMRX_DEFS_SVH
`define BMRX_DEFS_SVH

`define BMRX_DATA_W 8
`define BMRX_ADDR_W 7
`define BMRX_PC_W 13
`define BMRX_ACC_RST 8'h00
`define BMRX_ZERO_RST 1'b0
`define BMRX_PC_RST 13'h0000
`define BMRX_RET_CYCLES 2'h2
`define BMRX_ONE 8'h01
`define BMRX_ZERO_BYTE 8'h00

`endif

// *** hw/bmrx_exec.sv ***
/*
 * execution unit for increment, or-with-file, copy, load literal,
 * store accumulator and the two returns. holds the accumulator, the
 * zero flag and the program counter.
 * assumes: the sequencer presents one instruction per instruction
 * cycle with instr_valid, holding it while busy is high; the file
 * read port is combinational (file_rd_addr -> file_rd_data, same
 * cycle); the stack pop is a one-cycle strobe and stack_top holds the
 * top entry before the pop.
 */
`include "bmrx_defs.svh"

// Overview of operation
// (RULE_01) target bit 0 writes the accumulator, 1 writes the file register
// (RULE_02) file index is 7 bits, 0 to 127; target bit is one bit
// (RULE_03) increment adds one to the file register, updates only zero flag
// (RULE_04) or-with-file ors accumulator and register, updates only zero flag
// (RULE_05) copy moves register to target and updates zero flag
// (RULE_06) load literal puts 8-bit value in accumulator, no flag change
// (RULE_07) return-with-literal loads accumulator, pops stack top, two cycles
// (RULE_08) plain return pops stack top into the counter, two cycles
// (RULE_09) store accumulator writes accumulator to register, no flag change
// (RULE_10) zero flag set when result is zero, cleared otherwise
// (RULE_11) the non-return operations finish in a single cycle
module bmrx_exec (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// instruction in
	input wire logic instr_valid,
	input wire bmrx_pkg::bmrx_instr_t instr,
	output logic busy,
	// file register port
	output logic [`BMRX_ADDR_W-1:0] file_rd_addr,
	input wire logic [`BMRX_DATA_W-1:0] file_rd_data,
	output bmrx_pkg::bmrx_fwr_t file_wr,
	// return stack
	input wire logic [`BMRX_PC_W-1:0] stack_top,
	output logic stack_pop,
	// core state
	output logic [`BMRX_DATA_W-1:0] accum,
	output logic zero_flag,
	output logic [`BMRX_PC_W-1:0] pc,
	output logic done
);
	import bmrx_pkg::*;

	typedef enum logic {BMRX_ST_RUN, BMRX_ST_RET} bmrx_state_t;

	bmrx_state_t state_q, state_d;
	logic [`BMRX_DATA_W-1:0] accum_q, accum_d;
	logic zero_q, zero_d;
	logic [`BMRX_PC_W-1:0] pc_q, pc_d;
	bmrx_fwr_t fwr_q, fwr_d;
	logic pop_q, pop_d;
	logic done_q, done_d;
	logic busy_q, busy_d;
	logic [1:0] ret_cnt_q, ret_cnt_d;

	wire take = instr_valid && state_q == BMRX_ST_RUN;
	wire is_inc = instr.op == BMRX_OP_INCREMENT_FILE;
	wire is_or = instr.op == BMRX_OP_OR_ACCUM_FILE;
	wire is_copy = instr.op == BMRX_OP_COPY_FILE;
	wire is_ret = instr.op == BMRX_OP_RETURN ||
		instr.op == BMRX_OP_RETURN_LITERAL;
	wire is_lit = instr.op == BMRX_OP_LOAD_LITERAL;
	wire is_store = instr.op == BMRX_OP_STORE_ACCUM;
	wire is_ret_lit = instr.op == BMRX_OP_RETURN_LITERAL;
	// the address is 7 bits wide, so no index above 127 can exist
	assign file_rd_addr = instr.file_addr; // [RULE_02]
	wire [`BMRX_DATA_W-1:0] inc_res = file_rd_data + `BMRX_ONE; // [RULE_03]
	wire [`BMRX_DATA_W-1:0] or_res = accum_q | file_rd_data; // [RULE_04]
	wire [`BMRX_DATA_W-1:0] alu_res = is_inc ? inc_res :
		is_or ? or_res : file_rd_data; // [RULE_05]
	wire alu_op = is_inc || is_or || is_copy;
	wire res_zero = alu_res == `BMRX_ZERO_BYTE; // [RULE_10]
	wire [`BMRX_PC_W-1:0] pc_inc = pc_q + {{(`BMRX_PC_W-1){1'b0}}, 1'b1};
	// the return length is a count, so a longer refill needs no new state
	wire [1:0] ret_cnt_inc = ret_cnt_q + 2'h1;
	wire ret_last = ret_cnt_inc == `BMRX_RET_CYCLES;

	always_comb begin
		state_d = state_q;
		accum_d = accum_q;
		zero_d = zero_q;
		pc_d = pc_q;
		fwr_d = '0;
		pop_d = 1'b0;
		done_d = 1'b0;
		ret_cnt_d = '0;
		unique case (state_q)
			BMRX_ST_RUN: begin
				if (take) begin
					if (alu_op) begin
						zero_d = res_zero; // [RULE_03] [RULE_04] [RULE_05]
						// target select [RULE_01]
						if (instr.dest_file) begin
							fwr_d = '{we: 1'b1, addr: instr.file_addr,
								data: alu_res};
						end else begin
							accum_d = alu_res;
						end
						done_d = 1'b1; // [RULE_11]
					end else if (is_lit) begin
						accum_d = instr.literal; // [RULE_06]
						done_d = 1'b1; // [RULE_11]
					end else if (is_store) begin
						fwr_d = '{we: 1'b1, addr: instr.file_addr,
							data: accum_q}; // [RULE_09]
						done_d = 1'b1; // [RULE_11]
					end else if (is_ret) begin
						// pc loads now; second cycle is the flush slot
						if (is_ret_lit) begin
							accum_d = instr.literal; // [RULE_07]
						end
						pc_d = stack_top; // [RULE_07] [RULE_08]
						pop_d = 1'b1;
						ret_cnt_d = 2'h1;
						state_d = BMRX_ST_RET;
					end else begin
						// an empty slot still advances the counter
						done_d = 1'b1;
					end
					if (!is_ret) begin
						pc_d = pc_inc;
					end
				end
			end
			BMRX_ST_RET: begin
				// a request held during this cycle is not taken
				if (ret_last) begin
					state_d = BMRX_ST_RUN; // [RULE_07] [RULE_08]
					done_d = 1'b1;
				end else begin
					ret_cnt_d = ret_cnt_inc;
				end
			end
		endcase
		// busy rises with the pop and falls with done
		busy_d = state_d == BMRX_ST_RET;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BMRX_ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ret_cnt_q <= 2'h0;
		end else begin
			ret_cnt_q <= ret_cnt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accum_q <= `BMRX_ACC_RST;
		end else begin
			accum_q <= accum_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			zero_q <= `BMRX_ZERO_RST;
		end else begin
			zero_q <= zero_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= `BMRX_PC_RST;
		end else begin
			pc_q <= pc_d;
		end
	end

	// strobes drop back to idle on every cycle that does not set them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fwr_q <= '0;
		end else begin
			fwr_q <= fwr_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pop_q <= 1'b0;
		end else begin
			pop_q <= pop_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	// registered from the next state so busy needs no decode at the pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	assign busy = busy_q;
	assign file_wr = fwr_q;
	assign stack_pop = pop_q;
	assign accum = accum_q;
	assign zero_flag = zero_q;
	assign pc = pc_q;
	assign done = done_q;
endmodule

// *** hw/bmrx_pkg.sv ***
/*
 * types for the byte move / return execution unit.
 * assumes bmrx_defs.svh is on the include path.
 */
`include "bmrx_defs.svh"

package bmrx_pkg;

	typedef enum logic [2:0] {
		BMRX_OP_NONE,
		BMRX_OP_INCREMENT_FILE,
		BMRX_OP_OR_ACCUM_FILE,
		BMRX_OP_COPY_FILE,
		BMRX_OP_LOAD_LITERAL,
		BMRX_OP_STORE_ACCUM,
		BMRX_OP_RETURN_LITERAL,
		BMRX_OP_RETURN
	} bmrx_op_t;

	// one decoded instruction as handed in by the sequencer
	typedef struct packed {
		bmrx_op_t op;
		logic [`BMRX_ADDR_W-1:0] file_addr;
		logic dest_file;
		logic [`BMRX_DATA_W-1:0] literal;
	} bmrx_instr_t;

	// file register write request
	typedef struct packed {
		logic we;
		logic [`BMRX_ADDR_W-1:0] addr;
		logic [`BMRX_DATA_W-1:0] data;
	} bmrx_fwr_t;

endpackage
